// *** rtl/tof_cfg_defines.vh ***
`ifndef TOF_CFG_DEFINES_VH
`define TOF_CFG_DEFINES_VH

// register indexes; byte address is four times the index
`define IDX_TEMP 8'h57
`define IDX_TIMING 8'h5b
`define IDX_DUTY 8'h5c
`define IDX_SYNCINV 8'h6a
`define IDX_PATTERN 8'h6c
`define IDX_SUPSCALE 8'h4f

`define RST_TEMP_FIX 4'h8
`define RST_TIMING 24'h800000
`define RST_DUTY 24'h340000
`define RST_SYNCINV 24'h000000
`define RST_PATTERN 24'h000444
`define RST_SUPSCALE 6'h3f

// temperature register fields
`define TEMP_FIX_HI 12
`define TEMP_FIX_LO 9
`define TEMP_VAL_HI 8
`define TEMP_VAL_LO 0

// timing feature enables
`define BIT_SIMPLE_EN 23
`define BIT_SHUTTER_EN 22
`define BIT_EARLY_LIGHT 21

// duty and output format
`define DUTY_HI 23
`define DUTY_LO 18
`define BIT_LUMPED_DEAD 17
`define BIT_DYN_PDN 16
`define BIT_FLAGS_REPL 15
`define BIT_LINE_POL 14
`define BIT_FRAME_POL 13
`define BIT_ORDER_SEL 12

`define BIT_SYNC_INV 18

`define SCALE_SHIFT 6

// early illumination lead
`define EARLY_LEAD_US 15
`define MCLK_MHZ 200
`define EARLY_LEAD_CYC (`EARLY_LEAD_US * `MCLK_MHZ)

`endif

// *** rtl/tof_timing_output_config_regs.v ***
`timescale 1ns/1ps
`include "tof_cfg_defines.vh"

module tof_timing_output_config_regs #(
  parameter DATA_W = 16,
  parameter LEAD_CYC = `EARLY_LEAD_CYC
) (
  input wire MCLK_I,
  input wire SRST_I,
  input wire CYC_I,
  input wire STB_I,
  input wire WE_I,
  input wire [9:0] ADR_I,
  input wire [3:0] SEL_I,
  input wire [31:0] DAT_I,
  output reg [31:0] DAT_O,
  output reg ACK_O,
  input wire TEMP_VALID_I,
  input wire [8:0] TEMP_VALUE_I,
  input wire INTEG_REQ_I,
  input wire INTEG_END_I,
  input wire LINE_SYNC_I,
  input wire FRAME_SYNC_I,
  input wire [DATA_W-1:0] AMBIENT_DATA_I,
  input wire [DATA_W-1:0] FLAG_DATA_I,
  output reg [DATA_W-1:0] AUX_DATA_O,
  output reg LINE_SYNC_OUT_O,
  output reg FRAME_SYNC_OUT_O,
  output reg MOD_ON_O,
  output reg INTEG_START_O,
  output reg INTEG_ACTIVE_O,
  output reg SIMPLE_SETUP_O,
  output reg SHUTTER_ENABLE_O,
  output reg LUMPED_DEAD_TIME_O,
  output reg DYN_POWERDOWN_O,
  output reg OUTPUT_ORDER_SELECT_O,
  output reg [5:0] INTEG_FRACTION_O,
  output reg [5:0] SUPP_FRACTION_O
);

  localparam ST_IDLE = 2'd0;
  localparam ST_LEAD = 2'd1;
  localparam ST_INTEG = 2'd2;
  // last lead count, cut to the counter width on purpose
  localparam [31:0] LEAD_LAST = LEAD_CYC - 1;

  reg [3:0] temp_fix_ff;
  reg [8:0] die_temperature_value_ff;
  reg [23:0] timing_ff;
  reg [23:0] duty_ff;
  reg [23:0] syncinv_ff;
  reg [23:0] pattern_ff;
  reg [5:0] scale_ff;
  reg [1:0] state_ff;
  reg [1:0] nxt_state;
  reg [11:0] lead_cnt_ff;
  reg [11:0] nxt_lead_cnt;
  reg nxt_mod_on;
  reg nxt_integ_start;
  reg [31:0] nxt_rdata;
  wire [23:0] wmask;
  reg [11:0] scaled;

  wire req = CYC_I & STB_I & ~ACK_O;
  wire wr = req & WE_I;
  wire [7:0] idx = ADR_I[9:2];

  wire simple_timing_setup_enable = timing_ff[`BIT_SIMPLE_EN];
  wire early_light_start = timing_ff[`BIT_EARLY_LIGHT];
  wire [5:0] integration_fraction = duty_ff[`DUTY_HI:`DUTY_LO];
  wire flags_replace_background = duty_ff[`BIT_FLAGS_REPL];
  wire line_sync_polarity = duty_ff[`BIT_LINE_POL];
  wire frame_sync_polarity = duty_ff[`BIT_FRAME_POL];
  wire sync_outputs_invert = syncinv_ff[`BIT_SYNC_INV];

  // byte-lane write mask over the 24 implemented bits
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : lane
      assign wmask[g*8 +: 8] = {8{SEL_I[g]}};
    end
  endgenerate

  // read mux; reserved and write-only bits read zero
  always @* begin
    nxt_rdata = 32'h00000000;
    case (idx)
      `IDX_TEMP: begin
        nxt_rdata[`TEMP_FIX_HI:`TEMP_FIX_LO] = temp_fix_ff;
        nxt_rdata[`TEMP_VAL_HI:`TEMP_VAL_LO] = die_temperature_value_ff;
      end
      `IDX_TIMING: begin
        nxt_rdata[23:0] = timing_ff;
      end
      `IDX_DUTY: begin
        nxt_rdata[23:0] = duty_ff;
      end
      `IDX_SYNCINV: begin
        nxt_rdata[23:0] = syncinv_ff;
      end
      `IDX_PATTERN: begin
        nxt_rdata[23:0] = pattern_ff;
      end
      `IDX_SUPSCALE: begin
        nxt_rdata[5:0] = scale_ff;
      end
      default: begin
        nxt_rdata = 32'h00000000;
      end
    endcase
  end

  // bus slave: one ack per request, registered one cycle later; unmapped reads give zero
  always @(posedge MCLK_I) begin
    if (SRST_I) begin
      ACK_O <= 1'b0;
      DAT_O <= 32'h00000000;
    end else begin
      ACK_O <= req;
      DAT_O <= req ? nxt_rdata : 32'h00000000;
    end
  end

  // software-written registers
  always @(posedge MCLK_I) begin
    if (SRST_I) begin
      temp_fix_ff <= `RST_TEMP_FIX;
      timing_ff <= `RST_TIMING;
      duty_ff <= `RST_DUTY;
      syncinv_ff <= `RST_SYNCINV;
      pattern_ff <= `RST_PATTERN;
      scale_ff <= `RST_SUPSCALE;
    end else if (wr) begin
      case (idx)
        `IDX_TEMP: begin
          if (SEL_I[1]) begin
            // bits 23:13 are write-only and discarded
            temp_fix_ff <= DAT_I[`TEMP_FIX_HI:`TEMP_FIX_LO];
          end
        end
        `IDX_TIMING: begin
          timing_ff <= (timing_ff & ~wmask) | (DAT_I[23:0] & wmask);
        end
        `IDX_DUTY: begin
          duty_ff <= (duty_ff & ~wmask) | (DAT_I[23:0] & wmask);
        end
        `IDX_SYNCINV: begin
          syncinv_ff <= (syncinv_ff & ~wmask) | (DAT_I[23:0] & wmask);
        end
        `IDX_PATTERN: begin
          pattern_ff <= (pattern_ff & ~wmask) | (DAT_I[23:0] & wmask);
        end
        `IDX_SUPSCALE: begin
          if (SEL_I[0]) begin
            scale_ff <= DAT_I[5:0];
          end
        end
        default: begin
          temp_fix_ff <= temp_fix_ff;
        end
      endcase
    end
  end

  // latch sensor result on each valid conversion
  always @(posedge MCLK_I) begin
    if (SRST_I) begin
      die_temperature_value_ff <= 9'h000;
    end else if (TEMP_VALID_I) begin
      die_temperature_value_ff <= TEMP_VALUE_I;
    end
  end

  // illumination and integration sequencer
  always @* begin
    nxt_state = state_ff;
    nxt_lead_cnt = lead_cnt_ff;
    nxt_mod_on = MOD_ON_O;
    nxt_integ_start = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        if (INTEG_REQ_I) begin
          nxt_mod_on = 1'b1;
          nxt_lead_cnt = 12'h000;
          if (early_light_start) begin
            nxt_state = ST_LEAD;
          end else begin
            nxt_integ_start = 1'b1;
            nxt_state = ST_INTEG;
          end
        end
      end
      ST_LEAD: begin
        if (lead_cnt_ff == LEAD_LAST[11:0]) begin
          nxt_integ_start = 1'b1;
          nxt_state = ST_INTEG;
        end else begin
          nxt_lead_cnt = lead_cnt_ff + 12'h001;
        end
      end
      ST_INTEG: begin
        if (INTEG_END_I) begin
          nxt_mod_on = 1'b0;
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
        nxt_mod_on = 1'b0;
      end
    endcase
  end

  always @(posedge MCLK_I) begin
    if (SRST_I) begin
      state_ff <= ST_IDLE;
      lead_cnt_ff <= 12'h000;
      MOD_ON_O <= 1'b0;
      INTEG_START_O <= 1'b0;
      INTEG_ACTIVE_O <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      lead_cnt_ff <= nxt_lead_cnt;
      MOD_ON_O <= nxt_mod_on;
      INTEG_START_O <= nxt_integ_start;
      INTEG_ACTIVE_O <= (nxt_state == ST_INTEG);
    end
  end

  // supplementary frame fraction
  always @* begin
    scaled = integration_fraction * ({6'h00, scale_ff} + 12'h001);
  end

  // registered control and data outputs
  always @(posedge MCLK_I) begin
    if (SRST_I) begin
      SIMPLE_SETUP_O <= 1'b1;
      SHUTTER_ENABLE_O <= 1'b0;
      LUMPED_DEAD_TIME_O <= 1'b0;
      DYN_POWERDOWN_O <= 1'b0;
      OUTPUT_ORDER_SELECT_O <= 1'b0;
      INTEG_FRACTION_O <= 6'h0d;
      SUPP_FRACTION_O <= 6'h0d;
      LINE_SYNC_OUT_O <= 1'b0;
      FRAME_SYNC_OUT_O <= 1'b0;
      AUX_DATA_O <= {DATA_W{1'b0}};
    end else begin
      SIMPLE_SETUP_O <= simple_timing_setup_enable;
      SHUTTER_ENABLE_O <= timing_ff[`BIT_SHUTTER_EN];
      // placement only meaningful in simple mode
      LUMPED_DEAD_TIME_O <= simple_timing_setup_enable & duty_ff[`BIT_LUMPED_DEAD];
      DYN_POWERDOWN_O <= duty_ff[`BIT_DYN_PDN];
      OUTPUT_ORDER_SELECT_O <= duty_ff[`BIT_ORDER_SEL];
      INTEG_FRACTION_O <= integration_fraction;
      SUPP_FRACTION_O <= scaled[11:`SCALE_SHIFT];
      LINE_SYNC_OUT_O <= LINE_SYNC_I ^ line_sync_polarity ^ sync_outputs_invert;
      FRAME_SYNC_OUT_O <= FRAME_SYNC_I ^ frame_sync_polarity ^ sync_outputs_invert;
      AUX_DATA_O <= flags_replace_background ? FLAG_DATA_I : AMBIENT_DATA_I;
    end
  end

endmodule

// *** bench/tof_cfg_monitor.sv ***
`timescale 1ns/1ps
module tof_cfg_monitor (
  input logic MCLK_I,
  input logic SRST_I,
  input logic CYC_I,
  input logic STB_I,
  input logic [31:0] DAT_O,
  input logic ACK_O,
  input logic INTEG_REQ_I,
  input logic INTEG_END_I,
  input logic MOD_ON_O,
  input logic INTEG_START_O,
  input logic INTEG_ACTIVE_O,
  input logic SIMPLE_SETUP_O,
  input logic LUMPED_DEAD_TIME_O,
  input logic [5:0] INTEG_FRACTION_O,
  input logic [5:0] SUPP_FRACTION_O
);
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (SRST_I);
  sequence req_taken;
    INTEG_REQ_I && !MOD_ON_O;
  endsequence
  sequence start_once;
    INTEG_ACTIVE_O ##1 !INTEG_START_O;
  endsequence
  ack_resp_a: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O) else $error("ack missing");
  ack_pulse_a: assert property (ACK_O |=> !ACK_O) else $error("ack too long");
  rdat_idle_a: assert property (!ACK_O |-> DAT_O == 32'h0) else $error("read data outside ack");
  mod_start_a: assert property (req_taken |=> MOD_ON_O) else $error("modulation not started");
  start_pulse_a: assert property (INTEG_START_O |-> start_once) else $error("bad start pulse");
  active_mod_a: assert property (INTEG_ACTIVE_O |-> MOD_ON_O) else $error("integration without light");
  integ_stop_a: assert property (INTEG_END_I && INTEG_ACTIVE_O |=> !MOD_ON_O && !INTEG_ACTIVE_O)
    else $error("integration not ended");
  dead_simple_a: assert property (LUMPED_DEAD_TIME_O |-> SIMPLE_SETUP_O) else $error("lumped outside simple");
  supp_bound_a: assert property (SUPP_FRACTION_O <= INTEG_FRACTION_O) else $error("supp above base");
endmodule
bind tof_timing_output_config_regs tof_cfg_monitor tof_cfg_monitor_i (.MCLK_I(MCLK_I), .SRST_I(SRST_I),
  .CYC_I(CYC_I), .STB_I(STB_I), .DAT_O(DAT_O), .ACK_O(ACK_O), .INTEG_REQ_I(INTEG_REQ_I),
  .INTEG_END_I(INTEG_END_I), .MOD_ON_O(MOD_ON_O), .INTEG_START_O(INTEG_START_O),
  .INTEG_ACTIVE_O(INTEG_ACTIVE_O), .SIMPLE_SETUP_O(SIMPLE_SETUP_O),
  .LUMPED_DEAD_TIME_O(LUMPED_DEAD_TIME_O), .INTEG_FRACTION_O(INTEG_FRACTION_O),
  .SUPP_FRACTION_O(SUPP_FRACTION_O));

// *** bench/tof_timing_output_config_regs_test.sv ***
`timescale 1ns/1ps
module tof_timing_output_config_regs_test;
  localparam int LEAD = 5;
  logic MCLK_I = 0, SRST_I = 1, CYC_I = 0, STB_I = 0, WE_I = 0;
  logic [9:0] ADR_I = 0;
  logic [3:0] SEL_I = 4'h7;
  logic [31:0] DAT_I = 0, DAT_O, rd;
  logic ACK_O, TEMP_VALID_I = 0, INTEG_REQ_I = 0, INTEG_END_I = 0;
  logic [8:0] TEMP_VALUE_I = 0;
  logic LINE_SYNC_I = 0, FRAME_SYNC_I = 0;
  logic [15:0] AMBIENT_DATA_I = 16'h1234, FLAG_DATA_I = 16'habcd, AUX_DATA_O;
  logic LINE_SYNC_OUT_O, FRAME_SYNC_OUT_O, MOD_ON_O, INTEG_START_O, INTEG_ACTIVE_O;
  logic SIMPLE_SETUP_O, SHUTTER_ENABLE_O, LUMPED_DEAD_TIME_O, DYN_POWERDOWN_O, OUTPUT_ORDER_SELECT_O;
  logic [5:0] INTEG_FRACTION_O, SUPP_FRACTION_O;
  int num_errors = 0, checks = 0;
  always #2.5 MCLK_I = ~MCLK_I;
  tof_timing_output_config_regs #(.LEAD_CYC(LEAD)) tof_timing_output_config_regs_i (.*);
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task xfer(input logic w, input logic [7:0] a, input logic [23:0] d);
    CYC_I <= 1'b1;
    STB_I <= 1'b1;
    WE_I <= w;
    ADR_I <= {a, 2'b00};
    DAT_I <= {8'h00, d};
    do @(posedge MCLK_I); while (ACK_O !== 1'b1);
    rd = DAT_O;
    CYC_I <= 1'b0;
    STB_I <= 1'b0;
    @(posedge MCLK_I);
  endtask
  task rdc(input logic [7:0] a, input logic [23:0] e);
    xfer(1'b0, a, 24'h0);
    chk(rd, {8'h00, e});
  endtask
  // request integration, count edges to its start, then end it
  task integ(input int exp_n);
    int n;
    n = 0;
    INTEG_REQ_I <= 1'b1;
    @(posedge MCLK_I);
    INTEG_REQ_I <= 1'b0;
    do begin
      @(posedge MCLK_I);
      n++;
    end while (INTEG_START_O !== 1'b1 && n < 50);
    chk(n, exp_n);
    chk(MOD_ON_O, 1'b1);
    INTEG_END_I <= 1'b1;
    @(posedge MCLK_I);
    INTEG_END_I <= 1'b0;
    @(posedge MCLK_I);
    chk(MOD_ON_O, 1'b0);
  endtask
  task final_report;
    $display("errors=%0d checks=%0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (2000) @(posedge MCLK_I);
    num_errors++;
    final_report;
  end
  initial begin
    repeat (2) @(posedge MCLK_I);
    SRST_I <= 1'b0;
    @(posedge MCLK_I);
    rdc(8'h57, 24'h001000);
    rdc(8'h5b, 24'h800000);
    rdc(8'h5c, 24'h340000);
    rdc(8'h6a, 24'h000000);
    rdc(8'h6c, 24'h000444);
    rdc(8'h10, 24'h000000);
    chk(SIMPLE_SETUP_O, 1'b1);
    chk(SHUTTER_ENABLE_O, 1'b0);
    chk(INTEG_FRACTION_O, 6'h0d);
    chk(AUX_DATA_O, 16'h1234);
    TEMP_VALUE_I <= 9'h1f5;
    TEMP_VALID_I <= 1'b1;
    @(posedge MCLK_I);
    TEMP_VALID_I <= 1'b0;
    xfer(1'b1, 8'h57, 24'h001000);
    rdc(8'h57, 24'h0011f5);
    integ(1);
    xfer(1'b1, 8'h5b, 24'h600000);
    integ(LEAD + 1);
    LINE_SYNC_I <= 1'b1;
    FRAME_SYNC_I <= 1'b1;
    xfer(1'b1, 8'h5c, 24'hffd000);
    chk(SHUTTER_ENABLE_O, 1'b1);
    chk(SIMPLE_SETUP_O, 1'b0);
    chk(LUMPED_DEAD_TIME_O, 1'b0);
    chk(DYN_POWERDOWN_O, 1'b1);
    chk(OUTPUT_ORDER_SELECT_O, 1'b1);
    chk(INTEG_FRACTION_O, 6'h3f);
    chk(SUPP_FRACTION_O, 6'h3f);
    chk(AUX_DATA_O, 16'habcd);
    chk(LINE_SYNC_OUT_O, 1'b0);
    chk(FRAME_SYNC_OUT_O, 1'b1);
    xfer(1'b1, 8'h6a, 24'h040000);
    chk(LINE_SYNC_OUT_O, 1'b1);
    chk(FRAME_SYNC_OUT_O, 1'b0);
    xfer(1'b1, 8'h4f, 24'h00001f);
    xfer(1'b1, 8'h5b, 24'h800000);
    chk(LUMPED_DEAD_TIME_O, 1'b1);
    chk(SUPP_FRACTION_O, 6'h1f);
    rdc(8'h5c, 24'hffd000);
    rdc(8'h4f, 24'h00001f);
    final_report;
  end
endmodule
